// file: pkg/hprs_pkg.sv
// Package for the home position return sequencer: register map, fields, timing
package hprs_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	// Register offsets (word index)
	localparam logic [3:0] OFS_CTRL    = 4'h0;
	localparam logic [3:0] OFS_METHOD  = 4'h1;
	localparam logic [3:0] OFS_DIR     = 4'h2;
	localparam logic [3:0] OFS_DOGPOL  = 4'h3;
	localparam logic [3:0] OFS_HSPEED  = 4'h4;
	localparam logic [3:0] OFS_CSPEED  = 4'h5;
	localparam logic [3:0] OFS_SHIFT   = 4'h6;
	localparam logic [3:0] OFS_HPOS    = 4'h7;
	localparam logic [3:0] OFS_ACC     = 4'h8;
	localparam logic [3:0] OFS_DEC     = 4'h9;
	localparam logic [3:0] OFS_STATUS  = 4'ha;
	localparam logic [3:0] OFS_CURPOS  = 4'hb;
	// Control register fields
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_ABORT_BIT = 1;
	// Status register fields
	localparam int STAT_DONE_BIT  = 0;
	localparam int STAT_BUSY_BIT  = 1;
	localparam int STAT_ERR_BIT   = 2;
	localparam int STAT_MODE_BIT  = 3;
	// Method codes (lowest decimal digit of the method parameter)
	localparam logic [3:0] METHOD_DOG_Z     = 4'h8;
	localparam logic [3:0] METHOD_DOG_FRONT = 4'h9;
	localparam logic [3:0] METHOD_DOGLESS_Z = 4'h0;
	// Reset values
	localparam logic [31:0] RST_METHOD = 32'h0000_0008;
	localparam logic [31:0] RST_HSPEED = 32'h0000_0064;
	localparam logic [31:0] RST_CSPEED = 32'h0000_000a;
	localparam logic [31:0] RST_ZERO   = 32'h0000_0000;
	localparam logic [31:0] RST_ACCDEC = 32'h0000_0064;
	typedef enum logic [2:0] {
		HPRS_IDLE,
		HPRS_SEEK_DOG,
		HPRS_ON_DOG,
		HPRS_SEEK_Z,
		HPRS_SHIFT,
		HPRS_DONE
	} hprs_state_t;
endpackage

// file: verilog/hprs_top.sv
// Home position return sequencer with register port and motion command outputs
// Overview of operation
// RULE1 - Dog-Z mode: after dog front, reverse at creep
// RULE2 - Dog-Z mode: first Z after leaving dog is home
// RULE3 - Master sets manual bit, all table bits off
// RULE4 - Master sets position/speed system bit when two stations
// RULE5 - Method digit 8 selects dog first-Z
// RULE6 - Method digit 9 selects dog front end
// RULE7 - Front-end mode: home at dog front edge
// RULE8 - Dogless mode: first Z after start is home
// RULE9 - Travel at home speed until dog seen
// RULE10 - Creep speed once dog detected
// RULE11 - Offset home by shift distance from Z
// RULE12 - Use table entry 1 accel/decel constants
// RULE13 - On completion load current position with home value
// RULE14 - Direction from direction parameter
// RULE15 - Dog input polarity from polarity parameter
// RULE16 - Master changes table bits early, absorbing delay
// RULE17 - Stop motion and report completion status bit
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module hprs_top
	import hprs_pkg::*;
#(
	parameter int POS_W = 32
) (
	// Clock and reset
	input  wire logic                  CLK,
	input  wire logic                  RST_N,
	// Register port
	input  wire logic [ADDR_W-1:0]     ADDR,
	input  wire logic [DATA_W-1:0]     WDATA,
	input  wire logic                  WR,
	input  wire logic                  RD,
	output logic      [DATA_W-1:0]     RDATA,
	// Remote input bits from the fieldbus master
	input  wire logic                  AUTO_MANUAL_SELECT_BIT,
	input  wire logic [7:0]            TABLE_SELECT_BITS,
	input  wire logic                  POS_SPEED_SPEC_SELECT_BIT,
	// Sensors
	input  wire logic                  DOG_IN,
	input  wire logic                  INDEX_PULSE,
	input  wire logic [POS_W-1:0]      FEEDBACK_POS,
	// Motion command
	output logic                       MOVE_EN,
	output logic                       MOVE_DIR,
	output logic      [DATA_W-1:0]     MOVE_SPEED,
	output logic      [DATA_W-1:0]     ACC_TIME,
	output logic      [DATA_W-1:0]     DEC_TIME,
	output logic      [POS_W-1:0]      CURRENT_POS,
	output logic                       HOME_DONE
);
	import hprs_pkg::*;

	// ****************************************
	// Registers
	// ****************************************
	logic [DATA_W-1:0] method_reg, hspeed_reg, cspeed_reg, shift_reg, hpos_reg;
	logic [DATA_W-1:0] acc_reg, dec_reg;
	logic              dir_reg, dogpol_reg;
	logic              err_reg;
	logic [POS_W-1:0]  shift_target_reg;
	hprs_state_t       state_reg, state_next;

	wire logic       manual_mode = AUTO_MANUAL_SELECT_BIT && (TABLE_SELECT_BITS == 8'h00); // RULE3
	wire logic [3:0] low_digit   = 4'((method_reg % 32'd10));
	wire logic       is_dog_z    = (low_digit == METHOD_DOG_Z[3:0]); // RULE5
	wire logic       is_front    = (low_digit == METHOD_DOG_FRONT); // RULE6
	wire logic       is_dogless  = (low_digit == METHOD_DOGLESS_Z);
	wire logic       method_ok   = is_dog_z || is_front || is_dogless;
	wire logic       dog_active  = DOG_IN ^ ~dogpol_reg; // RULE15
	wire logic       wr_ctrl     = WR && (ADDR == OFS_CTRL);
	wire logic       start_cmd   = wr_ctrl && WDATA[CTRL_START_BIT] && manual_mode;
	wire logic       abort_cmd   = wr_ctrl && WDATA[CTRL_ABORT_BIT];
	wire logic       busy        = (state_reg != HPRS_IDLE) && (state_reg != HPRS_DONE);
	wire logic       shift_hit   = (FEEDBACK_POS == shift_target_reg);
	wire logic [POS_W-1:0] z_target = dir_reg ? FEEDBACK_POS - POS_W'(shift_reg)
	                                           : FEEDBACK_POS + POS_W'(shift_reg); // RULE11

	// ****************************************
	// Register write port
	// ****************************************
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			method_reg <= RST_METHOD;
			dir_reg    <= 1'b0;
			dogpol_reg <= 1'b1;
			hspeed_reg <= RST_HSPEED;
			cspeed_reg <= RST_CSPEED;
			shift_reg  <= RST_ZERO;
			hpos_reg   <= RST_ZERO;
			acc_reg    <= RST_ACCDEC;
			dec_reg    <= RST_ACCDEC;
		end else if (WR && !busy) begin
			// Parameters are frozen while a return is running
			case (ADDR)
				OFS_METHOD: method_reg <= WDATA;
				OFS_DIR:    dir_reg    <= WDATA[0];
				OFS_DOGPOL: dogpol_reg <= WDATA[0];
				OFS_HSPEED: hspeed_reg <= WDATA;
				OFS_CSPEED: cspeed_reg <= WDATA;
				OFS_SHIFT:  shift_reg  <= WDATA;
				OFS_HPOS:   hpos_reg   <= WDATA;
				OFS_ACC:    acc_reg    <= WDATA;
				OFS_DEC:    dec_reg    <= WDATA;
				default: ;
			endcase
		end
	end

	// ****************************************
	// Read port
	// ****************************************
	logic [DATA_W-1:0] rd_mux;
	always_comb begin
		case (ADDR)
			OFS_METHOD: rd_mux = method_reg;
			OFS_DIR:    rd_mux = {31'h0, dir_reg};
			OFS_DOGPOL: rd_mux = {31'h0, dogpol_reg};
			OFS_HSPEED: rd_mux = hspeed_reg;
			OFS_CSPEED: rd_mux = cspeed_reg;
			OFS_SHIFT:  rd_mux = shift_reg;
			OFS_HPOS:   rd_mux = hpos_reg;
			OFS_ACC:    rd_mux = acc_reg;
			OFS_DEC:    rd_mux = dec_reg;
			OFS_STATUS: rd_mux = {28'h0, manual_mode, err_reg, busy, HOME_DONE};
			OFS_CURPOS: rd_mux = DATA_W'(CURRENT_POS);
			default:    rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			RDATA <= 32'h0000_0000;
		else
			RDATA <= RD ? rd_mux : 32'h0000_0000;
	end

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			HPRS_IDLE, HPRS_DONE: begin
				if (start_cmd && method_ok)
					state_next = is_dogless ? HPRS_SEEK_Z : HPRS_SEEK_DOG;
			end
			HPRS_SEEK_DOG: begin
				if (dog_active)
					state_next = is_front ? HPRS_DONE : HPRS_ON_DOG; // RULE7
			end
			HPRS_ON_DOG: begin
				if (!dog_active)
					state_next = HPRS_SEEK_Z;
			end
			HPRS_SEEK_Z: begin
				if (INDEX_PULSE)
					state_next = HPRS_SHIFT; // RULE2 RULE8
			end
			HPRS_SHIFT: begin
				if (shift_hit)
					state_next = HPRS_DONE;
			end
			default: state_next = HPRS_IDLE;
		endcase
		if (abort_cmd)
			state_next = HPRS_IDLE;
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_reg        <= HPRS_IDLE;
			shift_target_reg <= '0;
			err_reg          <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (state_reg == HPRS_SEEK_Z && INDEX_PULSE)
				shift_target_reg <= z_target;
			// Set wins over clearing on a fresh start
			if (start_cmd && !method_ok)
				err_reg <= 1'b1;
			else if (start_cmd)
				err_reg <= 1'b0;
		end
	end

	// ****************************************
	// Motion command outputs
	// ****************************************
	wire logic moving    = (state_next != HPRS_IDLE) && (state_next != HPRS_DONE);
	wire logic reversing = (state_next == HPRS_ON_DOG) ||
	                       (is_dog_z && (state_next == HPRS_SEEK_Z || state_next == HPRS_SHIFT));
	wire logic use_home  = (state_next == HPRS_SEEK_DOG) ||
	                       (is_dogless && state_next == HPRS_SEEK_Z);
	wire logic finishing = (state_next == HPRS_DONE) && (state_reg != HPRS_DONE);

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			MOVE_EN     <= 1'b0;
			MOVE_DIR    <= 1'b0;
			MOVE_SPEED  <= 32'h0000_0000;
			ACC_TIME    <= 32'h0000_0000;
			DEC_TIME    <= 32'h0000_0000;
			CURRENT_POS <= '0;
			HOME_DONE   <= 1'b0;
		end else begin
			MOVE_EN    <= moving; // RULE17
			MOVE_DIR   <= dir_reg ^ reversing; // RULE14 RULE1
			MOVE_SPEED <= !moving ? 32'h0000_0000 : (use_home ? hspeed_reg : cspeed_reg); // RULE9 RULE10
			ACC_TIME   <= acc_reg; // RULE12
			DEC_TIME   <= dec_reg; // RULE12
			if (finishing)
				CURRENT_POS <= POS_W'(hpos_reg); // RULE13
			else
				CURRENT_POS <= busy ? FEEDBACK_POS : CURRENT_POS;
			HOME_DONE <= (state_next == HPRS_DONE); // RULE17
		end
	end
endmodule

// file: dv/hprs_properties.sv
// Port checker for the home return sequencer
`timescale 1ns/1ps
module hprs_checker
	import hprs_pkg::*;
#(parameter int POS_W = 32) (
	// Clock, reset, bus
	input wire logic             CLK,
	input wire logic             RST_N,
	input wire logic [3:0]       ADDR,
	input wire logic [31:0]      WDATA,
	input wire logic             WR,
	input wire logic             RD,
	input wire logic [31:0]      RDATA,
	// Remote bits and motion
	input wire logic             AUTO_MANUAL_SELECT_BIT,
	input wire logic [7:0]       TABLE_SELECT_BITS,
	input wire logic             MOVE_EN,
	input wire logic [31:0]      MOVE_SPEED,
	input wire logic [POS_W-1:0] CURRENT_POS,
	input wire logic             HOME_DONE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	done_no_move_a: assert property (HOME_DONE |-> !MOVE_EN) else $error("motion when done");
	idle_speed_a: assert property (!MOVE_EN |-> MOVE_SPEED == '0) else $error("speed when idle");
	read_idle_a: assert property (!$past(RD) |-> RDATA == '0) else $error("stray read data");
	unmapped_zero_a: assert property ($past(RD) && $past(ADDR) > OFS_CURPOS |-> RDATA == '0)
		else $error("unmapped read");
	done_holds_a: assert property (HOME_DONE && !WR |=> HOME_DONE) else $error("done dropped");
	pos_hold_a: assert property (HOME_DONE && $past(HOME_DONE) |-> $stable(CURRENT_POS))
		else $error("position moved");
	done_from_move_a: assert property ($rose(HOME_DONE) |-> $past(MOVE_EN)) else $error("done no motion");
	stop_done_a: assert property ($fell(MOVE_EN) && !$past(WR) |-> HOME_DONE) else $error("stop undone");
	start_by_write_a: assert property ($rose(MOVE_EN) |-> $past(WR) && $past(ADDR) == OFS_CTRL)
		else $error("start no write");
	manual_gate_a: assert property (WR && ADDR == OFS_CTRL && WDATA[0] && !MOVE_EN
		&& !(AUTO_MANUAL_SELECT_BIT && TABLE_SELECT_BITS == '0) |=> !MOVE_EN) else $error("start not manual");
endmodule
bind hprs_top hprs_checker #(.POS_W(POS_W)) i_hprs_checker (.*);

// file: dv/hprs_master_model.sv
// Fieldbus master model driving the remote input bits
`timescale 1ns/1ps
module hprs_master_model (
	// Bench request and remote bits
	input wire logic   clk,
	input wire logic   manual_req,
	output logic       auto_manual_select_bit,
	output logic [7:0] table_select_bits,
	output logic       pos_speed_spec_select_bit
);
	// Registered so bits settle before the bench starts, covering link delay
	always_ff @(posedge clk) begin
		auto_manual_select_bit <= manual_req;
		table_select_bits <= manual_req ? 8'h00 : 8'h01;
		pos_speed_spec_select_bit <= 1'b1;
	end
endmodule

// file: dv/tb.sv
// Self-checking testbench for the home return sequencer
`timescale 1ns/1ps
module tb;
	import hprs_pkg::*;
	logic CLK = 0, RST_N = 0, WR = 0, RD = 0, DOG_IN = 0, INDEX_PULSE = 0, manual_req = 1;
	logic [3:0] ADDR = '0;
	logic [31:0] WDATA = '0, FEEDBACK_POS = 32'h0000_0020, RDATA, MOVE_SPEED, ACC_TIME, DEC_TIME, CURRENT_POS;
	logic AUTO_MANUAL_SELECT_BIT, POS_SPEED_SPEC_SELECT_BIT, MOVE_EN, MOVE_DIR, HOME_DONE;
	logic [7:0] TABLE_SELECT_BITS;
	int failures = 0, checks_done = 0;
	hprs_master_model i_hprs_master_model (.clk(CLK), .manual_req(manual_req),
		.auto_manual_select_bit(AUTO_MANUAL_SELECT_BIT), .table_select_bits(TABLE_SELECT_BITS),
		.pos_speed_spec_select_bit(POS_SPEED_SPEC_SELECT_BIT));
	hprs_top i_hprs_top (.*);
	initial forever #4 CLK = ~CLK;
	task chk(input logic [31:0] s, e);
		checks_done++;
		if (s !== e) begin
			failures++;
			$display("wrong value at %0t: %h expected %h", $time, s, e);
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge CLK);
		WR <= 1'b1;
		ADDR <= a;
		WDATA <= d;
		@(posedge CLK);
		WR <= 1'b0;
		#1;
	endtask
	task rd(input logic [3:0] a);
		@(posedge CLK);
		RD <= 1'b1;
		ADDR <= a;
		@(posedge CLK);
		RD <= 1'b0;
		#1;
	endtask
	task go(input logic [31:0] m);
		wr(OFS_METHOD, m);
		wr(OFS_CTRL, 32'h0000_0001);
		chk(MOVE_EN, 1'b1);
		chk(MOVE_SPEED, RST_HSPEED);
	endtask
	task wait_done;
		for (int i = 0; i < 100 && HOME_DONE !== 1'b1; i++) @(posedge CLK) #1;
		chk(HOME_DONE, 1'b1);
		chk(CURRENT_POS, 32'h0000_0055);
	endtask
	task pulse_index(input logic exp_done);
		@(posedge CLK) INDEX_PULSE <= 1'b1;
		@(posedge CLK) INDEX_PULSE <= 1'b0;
		repeat (3) @(posedge CLK);
		#1 chk(HOME_DONE, exp_done);
	endtask
	task t_regs;
		rd(OFS_METHOD);
		chk(RDATA, RST_METHOD);
		rd(OFS_CSPEED);
		chk(RDATA, RST_CSPEED);
		rd(4'hf);
		chk(RDATA, RST_ZERO);
		$display("regs test over");
	endtask
	task t_front;
		wr(OFS_HPOS, 32'h0000_0055);
		go(32'h0000_0009);
		chk(MOVE_DIR, 1'b0);
		chk(ACC_TIME, RST_ACCDEC);
		chk(DEC_TIME, RST_ACCDEC);
		@(posedge CLK) DOG_IN <= 1'b1;
		wait_done;
		$display("front test over");
	endtask
	task t_dog_index;
		wr(OFS_DOGPOL, 32'h0000_0000);
		go(32'h0000_0008);
		@(posedge CLK) DOG_IN <= 1'b0;
		repeat (3) @(posedge CLK);
		#1 chk(MOVE_SPEED, RST_CSPEED);
		chk(MOVE_DIR, 1'b1);
		@(posedge CLK) DOG_IN <= 1'b1;
		pulse_index(1'b1);
		wait_done;
		$display("dog index test over");
	endtask
	task t_dogless;
		wr(OFS_SHIFT, 32'h0000_0004);
		go(32'h0000_0000);
		pulse_index(1'b0);
		@(posedge CLK) FEEDBACK_POS <= 32'h0000_0024;
		wait_done;
		$display("dogless test over");
	endtask
	task t_refuse;
		@(posedge CLK) manual_req <= 1'b0;
		wr(OFS_CTRL, 32'h0000_0001);
		chk(MOVE_EN, 1'b0);
		@(posedge CLK) manual_req <= 1'b1;
		go(32'h0000_0000);
		wr(OFS_CTRL, 32'h0000_0002);
		chk(MOVE_EN, 1'b0);
		wr(OFS_METHOD, 32'h0000_0005);
		wr(OFS_CTRL, 32'h0000_0001);
		chk(MOVE_EN, 1'b0);
		rd(OFS_STATUS);
		chk(RDATA[STAT_ERR_BIT], 1'b1);
		$display("refuse test over");
	endtask
	task test_done;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge CLK);
		RST_N <= 1'b1;
		t_regs;
		t_front;
		t_dog_index;
		t_dogless;
		t_refuse;
		test_done;
	end
	initial begin
		#100000;
		failures++;
		test_done;
	end
endmodule
